// File: fcps_pkg.sv
package fcps_pkg;

  // ----------------------------------------------------------------
  // clock and pulse timing
  // ----------------------------------------------------------------
  // times in tenths of a nanosecond so that printed figures stay exact
  localparam int CLK_PERIOD_DNS = 80;
  localparam int PULSE_MIN_DNS = 500;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_DNS + CLK_PERIOD_DNS - 1) / CLK_PERIOD_DNS;
  localparam int SCLK_MIN_DNS = 660;
  localparam int SCLK_MAX_DNS = 2650;
  localparam int SCLK_MIN_CYC = (SCLK_MIN_DNS + CLK_PERIOD_DNS - 1) / CLK_PERIOD_DNS;
  localparam int SCLK_MAX_CYC = SCLK_MAX_DNS / CLK_PERIOD_DNS;
  localparam int SCLK_FAST_DNS = 800;
  localparam int SCLK_FAST_HALF_CYC = SCLK_FAST_DNS / CLK_PERIOD_DNS / 2;
  localparam int SCLK_SLOW_MULT = 8;

  // ----------------------------------------------------------------
  // mode pin decode and byte framing
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] MODE_MASTER_PARALLEL = 3'h1;
  localparam logic [2:0] MODE_ASYNC_PERIPH = 3'h2;
  localparam logic [2:0] MODE_SYNC_PERIPH = 3'h3;
  localparam logic [2:0] MODE_SLAVE_PARALLEL = 3'h4;
  localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h7;
  localparam int RATE_BIT = 3;
  localparam logic [2:0] STROBE_HIGH_SLOT = 3'h7;
  localparam logic [1:0] PEND_NONE = 2'h0;
  localparam logic [1:0] PEND_LOAD = 2'h1;
  localparam logic [1:0] PEND_SKIP = 2'h2;
  localparam logic [1:0] PEND_AWAIT = 2'h3;
  localparam logic [3:0] BITS_AFTER_FIRST = 4'h7;

  typedef enum logic {FCPS_WAIT_INIT, FCPS_RUN} fcps_state_t;

  typedef struct packed {
    logic select_line_zero_n;
    logic select_line_one;
    logic write_n;
    logic read_n;
  } fcps_host_t;

  typedef struct packed {
    logic reset_n;
    logic program_request_n;
    logic init;
    logic sclk;
    logic din;
    logic [7:0] data;
    fcps_host_t host;
    logic [3:0] mode;
  } fcps_pins_t;

  localparam fcps_pins_t PINS_RST = '{reset_n: 1'b1, program_request_n: 1'b1, init: 1'b0, sclk: 1'b0,
    din: 1'b0, data: 8'h00, host: '{1'b1, 1'b0, 1'b1, 1'b1}, mode: 4'h0};

endpackage

// File: fcps_top.sv
`timescale 1ns/100ps
module fcps_top
  import fcps_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic reset_n_i,
  input wire logic program_request_n_i,
  input wire logic init_i,
  input wire logic [3:0] mode_i,
  input wire logic config_shift_clock_i,
  input wire logic serial_data_i,
  input wire logic [7:0] data_i,
  input wire fcps_host_t host_i,
  output logic config_shift_clock_o,
  output logic config_shift_clock_oe_o,
  output logic read_strobe_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic ready_o,
  output logic status_bit_lane_o,
  output logic status_bit_lane_oe_o,
  output logic downstream_data_o,
  output logic config_active_o
);

  // ----------------------------------------------------------------
  // mode helpers
  // ----------------------------------------------------------------
  function automatic logic own_clock(input logic [2:0] m);
    return (m == MODE_MASTER_SERIAL) || (m == MODE_MASTER_PARALLEL) || (m == MODE_ASYNC_PERIPH);
  endfunction

  function automatic logic serial_mode(input logic [2:0] m);
    return (m == MODE_MASTER_SERIAL) || (m == MODE_SLAVE_SERIAL);
  endfunction

  function automatic logic selected(input fcps_host_t h, input logic strobe_n);
    return !h.select_line_zero_n && h.select_line_one && !strobe_n;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  fcps_pins_t pins, s1_q, s2_q, prev_q;
  assign pins = '{reset_n_i, program_request_n_i, init_i, config_shift_clock_i, serial_data_i, data_i,
    host_i, mode_i};

  // prev_q only ever looks at the second stage
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s1_q <= PINS_RST;
      s2_q <= PINS_RST;
      prev_q <= PINS_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  // ----------------------------------------------------------------
  // restart pulse filters
  // ----------------------------------------------------------------
  logic [1:0] req_n;
  logic [1:0] hit;
  logic restart;
  assign req_n = {s2_q.program_request_n, s2_q.reset_n};
  assign restart = |hit;

  // a glitch shorter than the minimum never restarts configuration
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [3:0] cnt_q, cnt_d;
    always_comb begin
      cnt_d = '0;
      if (!req_n[g]) begin
        cnt_d = (cnt_q == 4'(PULSE_MIN_CYC)) ? cnt_q : cnt_q + 4'h1;
      end
    end
    always_ff @(posedge clock_i) begin
      if (reset_i) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_d;
      end
    end
    assign hit[g] = !req_n[g] && (cnt_q == 4'(PULSE_MIN_CYC - 1));
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  fcps_state_t st_q, st_d;
  logic [3:0] mode_q, mode_d;
  logic [6:0] div_q, div_d;
  logic sclk_q, sclk_d;
  logic [2:0] cnt_q, cnt_d;
  logic strobe_q, strobe_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] hold_q, hold_d, shift_q, shift_d;
  logic [3:0] left_q, left_d;
  logic [1:0] pend_q, pend_d;
  logic bit_q, bit_d, dout_q, dout_d;
  logic ready_q, ready_d, lane_q, lane_d, lane_oe_q, lane_oe_d;
  logic [6:0] half;
  logic run, own, toggle, rise_en, fall_en, wr_act, wr_prev, rd_act, init_rise;

  assign run = (st_q == FCPS_RUN);
  assign own = run && own_clock(mode_q[2:0]);
  // slow rate is eight times the fast half period
  assign half = mode_q[RATE_BIT] ? 7'(SCLK_FAST_HALF_CYC * SCLK_SLOW_MULT) : 7'(SCLK_FAST_HALF_CYC);
  assign toggle = own && (div_q == half - 7'h1);
  assign rise_en = own ? (toggle && !sclk_q) : (run && s2_q.sclk && !prev_q.sclk);
  assign fall_en = own ? (toggle && sclk_q) : (run && !s2_q.sclk && prev_q.sclk);
  assign wr_act = selected(s2_q.host, s2_q.host.write_n);
  assign wr_prev = selected(prev_q.host, prev_q.host.write_n);
  assign rd_act = selected(s2_q.host, s2_q.host.read_n);
  assign init_rise = s2_q.init && !prev_q.init;

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    div_d = div_q;
    sclk_d = sclk_q;
    cnt_d = cnt_q;
    strobe_d = strobe_q;
    addr_d = addr_q;
    hold_d = hold_q;
    shift_d = shift_q;
    left_d = left_q;
    pend_d = pend_q;
    bit_d = bit_q;
    dout_d = dout_q;
    ready_d = ready_q;
    lane_d = ready_q;
    lane_oe_d = 1'b0;
    if (restart) begin
      st_d = FCPS_WAIT_INIT;
      div_d = '0;
      sclk_d = 1'b0;
      cnt_d = '0;
      strobe_d = 1'b0;
      addr_d = '0;
      left_d = '0;
      pend_d = PEND_NONE;
      dout_d = 1'b1;
      ready_d = 1'b0;
    end else begin
      unique case (st_q)
        FCPS_WAIT_INIT: begin
          if (init_rise) begin
            st_d = FCPS_RUN;
            mode_d = s2_q.mode;
            ready_d = 1'b1;
          end
        end
        FCPS_RUN: begin
          if (own) begin
            div_d = toggle ? 7'h0 : div_q + 7'h1;
            sclk_d = toggle ? !sclk_q : sclk_q;
          end
          if (rise_en) begin
            bit_d = s2_q.din;
            if (mode_q[2:0] == MODE_MASTER_PARALLEL) begin
              cnt_d = cnt_q + 3'h1;
              // strobe high only in the eighth slot
              strobe_d = (cnt_d == STROBE_HIGH_SLOT);
              // byte taken as the strobe rises
              if (cnt_d == STROBE_HIGH_SLOT) begin
                hold_d = s2_q.data;
                pend_d = PEND_SKIP;
              end
              // next address placed as the strobe falls
              if (cnt_q == STROBE_HIGH_SLOT) begin
                addr_d = addr_q + ADDR_W'(1);
              end
            end else if ((mode_q[2:0] == MODE_SYNC_PERIPH || mode_q[2:0] == MODE_SLAVE_PARALLEL) && wr_act) begin
              hold_d = s2_q.data;
              // slave parallel bytes are kept, never queued downstream
              pend_d = (mode_q[2:0] == MODE_SYNC_PERIPH) ? PEND_SKIP : PEND_NONE;
            end else if (pend_q == PEND_AWAIT) begin
              pend_d = PEND_SKIP;
            end
          end
          if (fall_en) begin
            if (serial_mode(mode_q[2:0])) begin
              // captured bit leaves on the following fall
              dout_d = bit_q;
            end else begin
              if (left_q != 4'h0) begin
                dout_d = shift_q[7];
                shift_d = {shift_q[6:0], 1'b0};
                left_d = left_q - 4'h1;
              end
              // first fall skipped, bit seven on the next
              if (pend_q == PEND_SKIP) begin
                pend_d = PEND_LOAD;
              end else if (pend_q == PEND_LOAD) begin
                dout_d = hold_q[7];
                shift_d = {hold_q[6:0], 1'b0};
                left_d = BITS_AFTER_FIRST;
                pend_d = PEND_NONE;
              end
            end
          end
          if (mode_q[2:0] == MODE_ASYNC_PERIPH) begin
            // ready back once the byte is fully out
            if (!ready_q && pend_q == PEND_NONE && left_q == 4'h0) begin
              ready_d = 1'b1;
            end
            // latch on write release and drop ready
            if (wr_prev && !wr_act && ready_q) begin
              hold_d = prev_q.data;
              pend_d = PEND_AWAIT;
              ready_d = 1'b0;
            end
            // ready shown on the status lane during a read
            lane_oe_d = rd_act;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_q <= FCPS_WAIT_INIT;
      mode_q <= '0;
      div_q <= '0;
      sclk_q <= 1'b0;
      cnt_q <= '0;
      strobe_q <= 1'b0;
      addr_q <= '0;
      hold_q <= '0;
      shift_q <= '0;
      left_q <= '0;
      pend_q <= PEND_NONE;
      bit_q <= 1'b0;
      dout_q <= 1'b1;
      ready_q <= 1'b0;
      lane_q <= 1'b0;
      lane_oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      cnt_q <= cnt_d;
      strobe_q <= strobe_d;
      addr_q <= addr_d;
      hold_q <= hold_d;
      shift_q <= shift_d;
      left_q <= left_d;
      pend_q <= pend_d;
      bit_q <= bit_d;
      dout_q <= dout_d;
      ready_q <= ready_d;
      lane_q <= lane_d;
      lane_oe_q <= lane_oe_d;
    end
  end

  assign config_shift_clock_o = sclk_q;
  assign config_shift_clock_oe_o = own;
  assign read_strobe_o = strobe_q;
  assign addr_o = addr_q;
  assign ready_o = ready_q;
  assign status_bit_lane_o = lane_q;
  assign status_bit_lane_oe_o = lane_oe_q;
  assign downstream_data_o = dout_q;
  assign config_active_o = run;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // helpers: low slots before each strobe rise, cycles between clock rises
  logic [2:0] lowcnt_q;
  logic [9:0] per_q;
  logic per_ok_q;
  always_ff @(posedge clock_i) begin
    if (reset_i || restart) begin
      lowcnt_q <= '0;
      per_q <= '0;
      per_ok_q <= 1'b0;
    end else begin
      if (rise_en) begin
        lowcnt_q <= strobe_q ? 3'h0 : lowcnt_q + 3'h1;
      end
      per_q <= rise_en ? 10'h0 : per_q + 10'h1;
      per_ok_q <= per_ok_q || (rise_en && own);
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  a_strobe_low_slots: assert property ($rose(strobe_q) |-> lowcnt_q == 3'h7)
    else $error("read strobe rose without seven low clock periods");
  a_byte_delay: assert property (pend_q == PEND_SKIP && fall_en && !restart |=> pend_q == PEND_LOAD)
    else $error("byte did not wait the extra half clock");
  a_first_bit_out: assert property (pend_q == PEND_LOAD && fall_en && !restart |=> dout_q == $past(hold_q[7]))
    else $error("first downstream bit is not bit seven of the byte");
  a_serial_pass: assert property (run && serial_mode(mode_q[2:0]) && fall_en && !restart
    |=> dout_q == $past(bit_q))
    else $error("serial bit not forwarded on the falling edge");
  a_fast_period: assert property (rise_en && own && per_ok_q && !mode_q[RATE_BIT]
    |-> per_q >= 10'(SCLK_MIN_CYC - 1) && per_q <= 10'(SCLK_MAX_CYC - 1))
    else $error("fast configuration clock period out of range");
  a_slow_period: assert property (rise_en && own && per_ok_q && mode_q[RATE_BIT]
    |-> per_q >= 10'(SCLK_MIN_CYC * SCLK_SLOW_MULT - 1) && per_q <= 10'(SCLK_MAX_CYC * SCLK_SLOW_MULT - 1))
    else $error("slow configuration clock period out of range");
  a_mode_capture: assert property (!run && init_rise && !restart |=> run && mode_q == $past(s2_q.mode))
    else $error("mode pins not captured on init rise");
  a_reset_restart: assert property (!s2_q.reset_n [*7] |=> !run)
    else $error("long reset pulse did not restart configuration");
  a_program_restart: assert property (!s2_q.program_request_n [*7] |=> !run)
    else $error("long program pulse did not restart configuration");
  a_status_lane: assert property (run && mode_q[2:0] == MODE_ASYNC_PERIPH && rd_act && !restart
    |=> status_bit_lane_oe_o && status_bit_lane_o == $past(ready_q))
    else $error("status lane not driven with ready during read");
  a_addr_step: assert property ($fell(strobe_q) && !$past(restart) |-> addr_q == $past(addr_q) + ADDR_W'(1))
    else $error("address not advanced at strobe fall");
  a_sample_rise: assert property ($rose(strobe_q) |-> hold_q == $past(s2_q.data))
    else $error("byte not sampled at strobe rise");
  a_no_forward: assert property (run && mode_q[2:0] == MODE_SLAVE_PARALLEL |-> dout_q && left_q == 4'h0)
    else $error("slave parallel data forwarded downstream");
  a_ready_drop: assert property (run && mode_q[2:0] == MODE_ASYNC_PERIPH && ready_q && wr_prev && !wr_act
    && !restart |=> !ready_q ##1 !ready_q)
    else $error("ready did not drop after a latched write");

  c_parallel_byte: cover property ($rose(strobe_q) ##[1:200] pend_q == PEND_NONE && left_q == 4'h7);
  c_async_write: cover property (run && mode_q[2:0] == MODE_ASYNC_PERIPH && $fell(ready_q) ##[1:300] ready_q);
  c_restart: cover property (run ##1 !run);

endmodule

// File: fcps_far_model.sv
`timescale 1ns/100ps
module fcps_far_model
  import fcps_pkg::*;
(
  input wire logic sclk_i,
  input wire logic [17:0] addr_i,
  input wire logic ext_run_i,
  output logic [7:0] mem_data_o,
  output logic serial_data_o,
  output logic ext_clock_o
);
  // ----------------------------------------------------------------
  // memory and serial source
  // ----------------------------------------------------------------
  logic [15:0] pat_q = 16'hB38D;
  // byte follows address
  // byte depends on the address only, so it is steady around the strobe rise
  assign mem_data_o = addr_i[7:0] ^ 8'hA5;
  always @(negedge sclk_i) begin
    pat_q <= {pat_q[14:0], pat_q[15]};
  end
  assign serial_data_o = pat_q[15];
  // clock only in frames
  // stands low outside frames; the bench opens a frame well after init
  initial begin
    ext_clock_o = 1'h0;
    forever begin
      wait (ext_run_i);
      #3;
      while (ext_run_i) begin
        #32 ext_clock_o = 1'h1;
        #32 ext_clock_o = 1'h0;
      end
    end
  end
endmodule

// File: fcps_top_tb.sv
`timescale 1ns/100ps
module fcps_top_tb;
  import fcps_pkg::*;
  logic clock_i = 1'h0;
  logic reset_i = 1'h1;
  logic reset_n = 1'h1;
  logic prog_n = 1'h1;
  logic init = 1'h0;
  logic ext_run = 1'h0;
  logic host_drv = 1'h0;
  logic [3:0] mode = 4'h0;
  logic [7:0] host_data = 8'h00;
  fcps_host_t host = PINS_RST.host;
  logic [7:0] mem_data, byte_src, data_w;
  logic [17:0] addr;
  logic ser, ext_clk, sclk, sclk_oe, strobe, ready, lane, lane_oe, dout, active;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  // the status lane is shared: whoever is enabled sets bit 7
  assign byte_src = host_drv ? host_data : mem_data;
  assign data_w = {lane_oe ? lane : byte_src[7], byte_src[6:0]};

  fcps_top #(.ADDR_W(18)) dut_u (
    .clock_i(clock_i), .reset_i(reset_i), .reset_n_i(reset_n), .program_request_n_i(prog_n),
    .init_i(init), .mode_i(mode), .config_shift_clock_i(ext_clk), .serial_data_i(ser),
    .data_i(data_w), .host_i(host), .config_shift_clock_o(sclk), .config_shift_clock_oe_o(sclk_oe),
    .read_strobe_o(strobe), .addr_o(addr), .ready_o(ready), .status_bit_lane_o(lane),
    .status_bit_lane_oe_o(lane_oe), .downstream_data_o(dout), .config_active_o(active)
  );
  fcps_far_model far_u (
    .sclk_i(sclk), .addr_i(addr), .ext_run_i(ext_run),
    .mem_data_o(mem_data), .serial_data_o(ser), .ext_clock_o(ext_clk)
  );

  // ----------------------------------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------------------------------
  initial begin
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("wrong value at %0t: run did not finish", $time);
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock_i);
      #1;
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = sclk;
      1: pick = strobe;
      default: pick = active;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v, output int n);
    n = 0;
    while (pick(s) !== v && n < 3000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic edge_to(input int s, input logic v);
    int n;
    wait_for(s, ~v, n);
    wait_for(s, v, n);
  endtask
  // first bit leaves on the second fall, then one bit on each fall
  task automatic shift_chk(input logic [7:0] b);
    edge_to(0, 1'h0);
    for (int i = 7; i >= 0; i--) begin
      edge_to(0, 1'h0);
      tick(2);
      check(dout, b[i], "downstream bit");
    end
  endtask
  task automatic chk_period(input int half);
    int hi, lo, m;
    m = half / SCLK_FAST_HALF_CYC;
    edge_to(0, 1'h1);
    wait_for(0, 1'h0, hi);
    wait_for(0, 1'h1, lo);
    check(hi + lo, 2 * half, "clock period");
    check((hi + lo) * CLK_PERIOD_DNS inside {[SCLK_MIN_DNS * m:SCLK_MAX_DNS * m]}, 1, "period range");
  endtask
  task automatic start(input logic [3:0] m);
    int n;
    init = 1'h0;
    mode = m;
    tick(8);
    init = 1'h1;
    wait_for(2, 1'h1, n);
    check(n, 3, "capture delay");
  endtask
  task automatic pulse(input int pin, input int n);
    if (pin == 0) prog_n = 1'h0;
    else reset_n = 1'h0;
    tick(n);
    prog_n = 1'h1;
    reset_n = 1'h1;
  endtask
  task automatic restart(input int pin);
    pulse(pin, 5);
    tick(15);
    check(active, 1'h1, "short pulse ignored");
    pulse(pin, 7);
    tick(6);
    check({active, sclk_oe, dout}, 3'h1, "restart");
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int n, bad;
    logic [17:0] a;
    logic b;
    tick(20);
    reset_i = 1'h0;
    tick(4);
    start({1'h0, MODE_MASTER_PARALLEL});
    edge_to(1, 1'h1);
    check(addr, 0, "first address");
    shift_chk(8'hA5);
    mode = 4'h0;
    chk_period(SCLK_FAST_HALF_CYC);
    edge_to(1, 1'h1);
    a = addr;
    wait_for(1, 1'h0, n);
    check(n, 2 * SCLK_FAST_HALF_CYC, "strobe high");
    wait_for(1, 1'h1, n);
    check(n, 14 * SCLK_FAST_HALF_CYC, "strobe low");
    check(addr, a + 18'h1, "next address");
    $display("test master parallel done");
    restart(0);
    start({1'h1, MODE_MASTER_SERIAL});
    chk_period(SCLK_FAST_HALF_CYC * SCLK_SLOW_MULT);
    for (int k = 0; k < 4; k++) begin
      edge_to(0, 1'h1);
      b = ser;
      edge_to(0, 1'h0);
      tick(2);
      check(dout, b, "serial pass");
    end
    $display("test master serial done");
    restart(1);
    start({1'h0, MODE_ASYNC_PERIPH});
    tick(190);
    host = '{1'h0, 1'h1, 1'h1, 1'h0};
    tick(8);
    check({lane_oe, lane}, 2'h3, "status drive");
    host = PINS_RST.host;
    tick(8);
    check(lane_oe, 1'h0, "status release");
    // second write waits for the next clock fall after ready returns
    for (int j = 0; j < 2; j++) begin
      // write while ready
      // start just after a clock fall so the latch lands just after the second rise, before the third
      edge_to(0, 1'h0);
      host_drv = 1'h1;
      host_data = (j == 0) ? 8'h5A : 8'hC3;
      host = '{1'h0, 1'h1, 1'h0, 1'h1};
      tick(13);
      host = PINS_RST.host;
      tick(1);
      host_drv = 1'h0;
      tick(4);
      check(ready, 1'h0, "busy after write");
      edge_to(0, 1'h1);
      shift_chk(host_data);
      check(ready, 1'h1, "ready again");
    end
    $display("test async peripheral done");
    restart(0);
    start({1'h0, MODE_SLAVE_PARALLEL});
    tick(130);
    host_drv = 1'h1;
    host_data = 8'h00;
    host = '{1'h0, 1'h1, 1'h0, 1'h1};
    ext_run = 1'h1;
    bad = 0;
    repeat (300) begin
      tick(1);
      if (dout !== 1'h1 || sclk_oe !== 1'h0) bad++;
    end
    check(bad, 0, "nothing forwarded");
    ext_run = 1'h0;
    host = PINS_RST.host;
    host_drv = 1'h0;
    $display("test slave parallel done");
    print_verdict();
  end
endmodule
